//--- stcm_pkg.sv
// stcm_pkg: constants shared by the tributary column mapper.
// assumes: columns are 1-based, one byte per column, frame count up to 64x270.
package stcm_pkg;

  // frame geometry
  localparam int         COL_W        = 15;
  localparam logic [14:0] COLS_PER_N  = 15'h10e;  // 270
  localparam logic [8:0] SOH_COLS     = 9'h009;   // 9 per N
  localparam logic [8:0] VC4_COLS     = 9'h105;   // 261
  localparam logic [8:0] VC4_POH_LAST = 9'h003;   // columns 1..3
  localparam logic [8:0] TU3_FIRST    = 9'h004;   // column 4
  localparam logic [8:0] LO_FIRST     = 9'h00a;   // column 10
  localparam logic [7:0] TUG3_CNT     = 8'h03;
  localparam logic [7:0] TUG2_CNT     = 8'h07;
  localparam logic [7:0] TU2_SPAN     = 8'h15;    // 21
  localparam logic [7:0] TU12_SPAN    = 8'h3f;    // 63

  // line rate code, N = 4**rate
  localparam logic [1:0] RATE_STM1    = 2'h0;
  localparam logic [1:0] RATE_STM4    = 2'h1;
  localparam logic [1:0] RATE_STM16   = 2'h2;
  localparam logic [1:0] RATE_STM64   = 2'h3;

  // higher-order payload structure
  localparam logic [1:0] HO_AU4       = 2'h0;
  localparam logic [1:0] HO_AU4_4C    = 2'h1;
  localparam logic [1:0] HO_AU4_16C   = 2'h2;

  // lower-order structure inside each VC-4
  localparam logic [1:0] LO_NONE      = 2'h0;
  localparam logic [1:0] LO_TU12      = 2'h1;
  localparam logic [1:0] LO_TU2       = 2'h2;
  localparam logic [1:0] LO_TU3       = 2'h3;

  // configuration after reset
  localparam logic [1:0] RATE_RST     = RATE_STM1;
  localparam logic [1:0] HO_RST       = HO_AU4;
  localparam logic [1:0] LO_RST       = LO_TU12;

  // buffer depth in the data path
  localparam int         FIFO_DEPTH   = 4;

endpackage

//--- stcm_mapper.sv
// stcm_mapper: tags each frame byte with its higher- and lower-order address.
// assumes: an upstream aligner on sys_clk gives a frame start and a 1-based
// column with every byte; downstream per-tributary logic drains the fifo.
//
// Notes on behaviour
// [RL1] frame is N*270 columns, first N*9 overhead
// [RL2] each payload column gets a time-slot number
// [RL3] STM-64 nests AUG-16, AUG-4, AUG-1, AU-3 zero
// [RL4] STM-64 AU-4 at 1+16(D-1)+4(C-1)+(B-1)+64(X-1)
// [RL5] STM-64 AU-4-4c in fours every 64 columns
// [RL6] STM-64 AU-4-16c in sixteens every 64 columns
// [RL7] STM-16 AU-4 at 1+4(C-1)+(B-1)+16(X-1)
// [RL8] STM-16 AU-4-4c in fours every 16 columns
// [RL9] STM-4 AU-4 at 1+(B-1)+4(X-1)
// [RL10] single signals addressed with all-zero figures
// [RL11] VC-4 is 261 columns: 3 overhead, 6, 252
// [RL12] time slots numbered left to right in VC-4
// [RL13] VC-4 holds 3 TUG-3, 7 TUG-2, 3 TU-12
// [RL14] TU-12 at 10+(K-1)+3(L-1)+21(M-1)+63(X-1)
// [RL15] TU-2 at 10+(K-1)+3(L-1)+21(X-1)
// [RL16] TU-3 at 4+(K-1)+3(X-1)
// [RL17] bit 1 is the byte msb, sent first
// [RL18] every byte leaves tagged, in column order
// [RL19] aligner supplies frame start and 1-based column

`timescale 1ns/1ps
`default_nettype none

module stcm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  wire          full   = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire          empty  = (wr_r == rd_r);
  wire          push   = clk_en && in_valid && !full;
  wire          pop    = clk_en && out_ready && !empty;

  // a frozen fifo offers no handshake, so nothing is lost while clk_en is low
  assign in_ready  = clk_en && !full;
  assign out_valid = clk_en && !empty;
  assign out_data  = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

  // storage needs no reset; out_valid hides it until written
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

module stcm_mapper
  import stcm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [1:0]        cfg_rate,
  input  wire logic [1:0]        cfg_ho,
  input  wire logic [1:0]        cfg_lo,
  output logic                   cfg_err,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [7:0]        in_data,
  input  wire logic              in_frame_start,
  input  wire logic [COL_W-1:0]  in_col,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [7:0]             out_data,
  output logic                   out_frame_start,
  output logic [COL_W-1:0]       out_col,
  output logic                   out_range_err,
  output logic                   out_overhead,
  output logic [2:0]             out_ho_d,
  output logic [2:0]             out_ho_c,
  output logic [2:0]             out_ho_b,
  output logic [12:0]            out_ho_col,
  output logic [6:0]             out_ho_ts,
  output logic [8:0]             out_vc4_col,
  output logic                   out_lo_valid,
  output logic [1:0]             out_lo_k,
  output logic [2:0]             out_lo_l,
  output logic [1:0]             out_lo_m,
  output logic [6:0]             out_lo_col,
  output logic [5:0]             out_lo_ts
);
  localparam int TAG_W = 85;

  function automatic logic [2:0] fig(input logic [1:0] v);
    fig = {1'b0, v} + 3'h1;
  endfunction

  function automatic logic [8:0] mod_by(input logic [8:0] v, input logic [8:0] d);
    mod_by = v % d;
  endfunction

  function automatic logic [8:0] div_by(input logic [8:0] v, input logic [8:0] d);
    div_by = v / d;
  endfunction

  // configuration held for a whole frame, retaken at each frame start
  logic [1:0] rate_r;
  logic [1:0] ho_r;
  logic [1:0] lo_r;
  logic       cfg_err_r;

  wire       take      = in_valid && in_ready;
  wire [1:0] rate      = in_frame_start ? cfg_rate : rate_r;
  wire [1:0] ho        = in_frame_start ? cfg_ho : ho_r;
  wire [1:0] lo        = in_frame_start ? cfg_lo : lo_r;
  wire       bad_cfg   = (ho == HO_AU4_4C && rate == RATE_STM1)
                       || (ho == HO_AU4_16C && (rate == RATE_STM1 || rate == RATE_STM4))
                       || (ho > HO_AU4_16C);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_r    <= RATE_RST;
      ho_r      <= HO_RST;
      lo_r      <= LO_RST;
      cfg_err_r <= 1'b0;
    end else if (clk_en && take && in_frame_start) begin  // [RL19]
      rate_r    <= cfg_rate;
      ho_r      <= cfg_ho;
      lo_r      <= cfg_lo;
      cfg_err_r <= bad_cfg;
    end
  end
  assign cfg_err = cfg_err_r;

  // N = 4**rate, so column interleave is a shift and a bit-slice
  wire [COL_W-1:0] c0     = in_col - 15'h0001;  // [RL19]
  wire [3:0]       n_log  = {1'b0, rate, 1'b0};
  wire [COL_W-1:0] q_full = c0 >> n_log;
  wire [8:0]       q      = q_full[8:0];
  // slot bits above N belong to the column index, not to the slot
  wire [5:0]       u_msk  = ~(6'h3f << n_log);
  wire [5:0]       u      = c0[5:0] & u_msk;
  wire             in_rng = (in_col != 15'h0000) && (q_full < COLS_PER_N);  // [RL1]
  wire             oh     = q < SOH_COLS;  // [RL1]

  // unused figures stay zero; the single-signal cases fall out of this
  wire [2:0] fig_b = (rate != RATE_STM1) ? fig(u[1:0]) : 3'h0;
  wire [2:0] fig_c = (rate == RATE_STM16 || rate == RATE_STM64) ? fig(u[3:2]) : 3'h0;
  wire [2:0] fig_d = (rate == RATE_STM64) ? fig(u[5:4]) : 3'h0;  // [RL3]

  logic [2:0]  ho_d;
  logic [2:0]  ho_c;
  logic [2:0]  ho_b;
  logic [12:0] ho_col;

  always_comb begin
    ho_d   = fig_d;
    ho_c   = 3'h0;
    ho_b   = 3'h0;
    ho_col = {4'h0, q} + 13'h0001;
    unique case (ho)
      HO_AU4: begin
        // [RL4] [RL7] [RL9] [RL10]
        ho_c   = fig_c;
        ho_b   = fig_b;
      end
      HO_AU4_4C: begin
        // [RL5] [RL8] [RL10]
        ho_c   = fig_c;
        ho_col = {2'b00, q, u[1:0]} + 13'h0001;
      end
      HO_AU4_16C: begin
        // [RL6] [RL10]
        ho_c   = 3'h0;
        ho_col = {q, u[3:0]} + 13'h0001;
      end
      default: begin
        ho_d   = 3'h0;
      end
    endcase
  end

  // slot within the N-column interleave cycle; a 4c owns four, a 16c sixteen
  wire [6:0] ho_ts = {1'b0, u} + 7'h01;  // [RL2]

  // vc-4 view exists only for plain au-4 payload columns
  wire       vc4_ok  = in_rng && !oh && ho == HO_AU4 && !bad_cfg;
  wire [8:0] vcol    = vc4_ok ? (q - SOH_COLS + 9'h001) : 9'h000;  // [RL11]
  wire       is_poh  = vcol <= VC4_POH_LAST;  // [RL11]
  // t3 runs up to 257, so all column math is nine bits wide
  wire [8:0] t3      = vcol - TU3_FIRST;
  wire [8:0] t       = vcol - LO_FIRST;
  wire [8:0] d_tug3  = {1'b0, TUG3_CNT};
  wire [8:0] d_tug2  = {1'b0, TUG2_CNT};
  wire [8:0] d_tu2   = {1'b0, TU2_SPAN};
  wire [8:0] d_tu12  = {1'b0, TU12_SPAN};
  wire [8:0] t_div3  = div_by(t, d_tug3);
  wire [8:0] t_div21 = div_by(t, d_tu2);

  // per-structure decode; the case below only selects
  wire       tu3_in  = vc4_ok && !is_poh;  // [RL16]
  wire       lo_in   = vc4_ok && vcol >= LO_FIRST;  // [RL11]
  wire [1:0] k_tu3   = 2'(mod_by(t3, d_tug3)) + 2'h1;  // [RL16]
  wire [6:0] x_tu3   = 7'(div_by(t3, d_tug3)) + 7'h01;
  wire [1:0] k_lo    = 2'(mod_by(t, d_tug3)) + 2'h1;  // [RL13]
  wire [2:0] l_lo    = 3'(mod_by(t_div3, d_tug2)) + 3'h1;
  wire [1:0] m_tu12  = 2'(mod_by(t_div21, d_tug3)) + 2'h1;  // [RL14]
  wire [6:0] x_tu2   = 7'(t_div21) + 7'h01;  // [RL15]
  wire [6:0] x_tu12  = 7'(div_by(t, d_tu12)) + 7'h01;  // [RL14]
  wire [5:0] ts_tu2  = 6'(mod_by(t, d_tu2)) + 6'h01;  // [RL12]
  wire [5:0] ts_tu12 = 6'(mod_by(t, d_tu12)) + 6'h01;  // [RL12]

  logic       lo_ok;
  logic [1:0] lo_k;
  logic [2:0] lo_l;
  logic [1:0] lo_m;
  logic [6:0] lo_col;
  logic [5:0] lo_ts;

  always_comb begin
    lo_ok  = 1'b0;
    lo_k   = 2'h0;
    lo_l   = 3'h0;
    lo_m   = 2'h0;
    lo_col = 7'h00;
    lo_ts  = 6'h00;
    unique case (lo)
      LO_TU3: begin
        if (tu3_in) begin  // [RL16]
          lo_ok  = 1'b1;
          lo_k   = k_tu3;
          lo_col = x_tu3;
          lo_ts  = {4'h0, k_tu3};  // [RL12]
        end
      end
      LO_TU2: begin
        if (lo_in) begin  // [RL15]
          lo_ok  = 1'b1;
          lo_k   = k_lo;
          lo_l   = l_lo;
          lo_col = x_tu2;
          lo_ts  = ts_tu2;
        end
      end
      LO_TU12: begin
        if (lo_in) begin  // [RL14]
          lo_ok  = 1'b1;
          lo_k   = k_lo;
          lo_l   = l_lo;
          lo_m   = m_tu12;
          lo_col = x_tu12;
          lo_ts  = ts_tu12;
        end
      end
      LO_NONE: begin
        lo_ok  = 1'b0;
      end
    endcase
  end

  // byte passes untouched: bit 7 carries bit 1, the first on the line
  wire             rng_err = !in_rng || bad_cfg;
  wire [TAG_W-1:0] tag_in = {  // [RL17]
    in_data,
    in_frame_start,
    in_col,
    rng_err,
    oh,
    ho_d,
    ho_c,
    ho_b,
    ho_col,
    ho_ts,
    vcol,
    lo_ok,
    lo_k,
    lo_l,
    lo_m,
    lo_col,
    lo_ts
  };
  wire [TAG_W-1:0] tag_out;

  // fifo keeps arrival order, so tags leave in frame column order
  stcm_fifo #(
    .W     (TAG_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (tag_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (tag_out)
  );  // [RL18]

  assign {
    out_data,
    out_frame_start,
    out_col,
    out_range_err,
    out_overhead,
    out_ho_d,
    out_ho_c,
    out_ho_b,
    out_ho_col,
    out_ho_ts,
    out_vc4_col,
    out_lo_valid,
    out_lo_k,
    out_lo_l,
    out_lo_m,
    out_lo_col,
    out_lo_ts
  } = tag_out;
endmodule

`default_nettype wire

//--- stcm_mapper_monitor.sv
// stcm_mapper_monitor: port-level checks of the column mapper.
// assumes: cfg held steady while bytes sit in the fifo.
`timescale 1ns/1ps
`default_nettype none
module stcm_mapper_monitor
  import stcm_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             reset_n,
  input wire logic             clk_en,
  input wire logic [1:0]       cfg_rate,
  input wire logic [1:0]       cfg_ho,
  input wire logic [1:0]       cfg_lo,
  input wire logic             cfg_err,
  input wire logic             in_valid,
  input wire logic             in_ready,
  input wire logic             in_frame_start,
  input wire logic             out_valid,
  input wire logic             out_ready,
  input wire logic [COL_W-1:0] out_col,
  input wire logic             out_range_err,
  input wire logic             out_overhead,
  input wire logic [6:0]       out_ho_ts,
  input wire logic [8:0]       out_vc4_col,
  input wire logic             out_lo_valid,
  input wire logic [1:0]       out_lo_k,
  input wire logic [6:0]       out_lo_col
);
  logic [6:0] n;
  logic       bad_cfg;
  // n = 4**rate, only valid while cfg is steady
  assign n = 7'h1 << {cfg_rate, 1'b0};
  assign bad_cfg = (cfg_ho == 2'h3) || (cfg_ho > cfg_rate);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_ovh_edge:
    assert property (out_valid && !out_range_err |-> out_overhead == (out_col <= 9 * n))
    else $error("overhead flag wrong");
  chk_range_top:
    assert property (out_valid && (out_col == 0 || out_col > 270 * n) |-> out_range_err)
    else $error("range flag missing");
  chk_ho_slot:
    assert property (out_valid && !out_range_err |-> out_ho_ts == (out_col - 1) % n + 1)
    else $error("ho time slot wrong");
  chk_tu3_col:
    assert property (out_valid && out_lo_valid && cfg_lo == LO_TU3
      |-> out_vc4_col == 4 + out_lo_k - 1 + 3 * (out_lo_col - 1))
    else $error("tu3 column wrong");
  chk_lo_place:
    assert property (out_valid && out_lo_valid |-> cfg_ho == HO_AU4
      && out_vc4_col >= ((cfg_lo == LO_TU3) ? 4 : 10))
    else $error("lo byte outside payload");
  chk_gate_off:
    assert property (!clk_en |-> !in_ready && !out_valid)
    else $error("handshake while frozen");
  chk_out_hold:
    assert property (out_valid && !out_ready && clk_en ##1 clk_en |-> out_valid && $stable(out_col))
    else $error("output word not held");
  chk_take_lat:
    assert property (in_valid && in_ready ##1 clk_en |-> out_valid)
    else $error("taken byte not shown");
  chk_cfg_flag:
    assert property (in_valid && in_ready && in_frame_start |=> cfg_err == $past(bad_cfg))
    else $error("cfg error flag wrong");
  cov_full: cover property (in_valid && !in_ready && clk_en);
  cov_tu3: cover property (out_valid && out_lo_valid && cfg_lo == LO_TU3);
  cov_err: cover property (cfg_err);
endmodule
bind stcm_mapper stcm_mapper_monitor u_mon (
  .sys_clk        (sys_clk),
  .reset_n        (reset_n),
  .clk_en         (clk_en),
  .cfg_rate       (cfg_rate),
  .cfg_ho         (cfg_ho),
  .cfg_lo         (cfg_lo),
  .cfg_err        (cfg_err),
  .in_valid       (in_valid),
  .in_ready       (in_ready),
  .in_frame_start (in_frame_start),
  .out_valid      (out_valid),
  .out_ready      (out_ready),
  .out_col        (out_col),
  .out_range_err  (out_range_err),
  .out_overhead   (out_overhead),
  .out_ho_ts      (out_ho_ts),
  .out_vc4_col    (out_vc4_col),
  .out_lo_valid   (out_lo_valid),
  .out_lo_k       (out_lo_k),
  .out_lo_col     (out_lo_col)
);
`default_nettype wire

//--- stcm_sink.sv
// stcm_sink: downstream per-tributary side, drains the mapper output.
// assumes: stall and slow driven by the bench off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module stcm_sink (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic slow,
  output logic     out_ready
);
  logic tog_r;
  // slow mode: ready every other cycle, keeps words queued
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
    end
  end
  assign out_ready = !stall && (!slow || tog_r);
endmodule
`default_nettype wire

//--- stcm_mapper_bench.sv
// stcm_mapper_bench: directed scenarios for the column mapper.
// assumes: stcm_sink drains the output; one config per frame.
`timescale 1ns/1ps
`default_nettype none
module stcm_mapper_bench
  import stcm_pkg::*;
;
  logic             sys_clk, in_ready, cfg_err, out_valid, out_ready, out_frame_start;
  logic             out_range_err, out_overhead, out_lo_valid;
  logic             reset_n = 1'b0, clk_en = 1'b1, in_valid = 1'b0, in_frame_start = 1'b0;
  logic             stall = 1'b0, slow = 1'b0;
  logic [1:0]       cfg_rate = 2'h0, cfg_ho = 2'h0, cfg_lo = 2'h1, out_lo_k, out_lo_m;
  logic [7:0]       in_data = 8'h00, out_data;
  logic [COL_W-1:0] in_col = 15'h1, out_col;
  logic [2:0]       out_ho_d, out_ho_c, out_ho_b, out_lo_l;
  logic [12:0]      out_ho_col;
  logic [6:0]       out_ho_ts, out_lo_col;
  logic [8:0]       out_vc4_col;
  logic [5:0]       out_lo_ts;
  int               error_cnt = 0, samples_checked = 0;
  stcm_mapper #(.DEPTH(4)) dut (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .clk_en          (clk_en),
    .cfg_rate        (cfg_rate),
    .cfg_ho          (cfg_ho),
    .cfg_lo          (cfg_lo),
    .cfg_err         (cfg_err),
    .in_valid        (in_valid),
    .in_ready        (in_ready),
    .in_data         (in_data),
    .in_frame_start  (in_frame_start),
    .in_col          (in_col),
    .out_valid       (out_valid),
    .out_ready       (out_ready),
    .out_data        (out_data),
    .out_frame_start (out_frame_start),
    .out_col         (out_col),
    .out_range_err   (out_range_err),
    .out_overhead    (out_overhead),
    .out_ho_d        (out_ho_d),
    .out_ho_c        (out_ho_c),
    .out_ho_b        (out_ho_b),
    .out_ho_col      (out_ho_col),
    .out_ho_ts       (out_ho_ts),
    .out_vc4_col     (out_vc4_col),
    .out_lo_valid    (out_lo_valid),
    .out_lo_k        (out_lo_k),
    .out_lo_l        (out_lo_l),
    .out_lo_m        (out_lo_m),
    .out_lo_col      (out_lo_col),
    .out_lo_ts       (out_lo_ts)
  );
  stcm_sink sink (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .stall     (stall),
    .slow      (slow),
    .out_ready (out_ready)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // holds valid until the edge that sees ready
  task automatic send(input logic [COL_W-1:0] col, input logic fs, input logic [7:0] d);
    in_valid = 1'b1;
    in_col = col;
    in_frame_start = fs;
    in_data = d;
    while (!in_ready) step();
    step();
    in_valid = 1'b0;
  endtask
  // returns with the word at the head, taken at the next edge
  task automatic take();
    int k;
    k = 0;
    while (!(out_valid && out_ready) && k < 64) begin
      step();
      k++;
    end
    if (k >= 64) begin
      error_cnt++;
      $display("[ERR] out_valid exp 1 got 0");
    end
  endtask
  task automatic frame(input logic [1:0] r, input logic [1:0] h, input logic [1:0] l);
    cfg_rate = r;
    cfg_ho = h;
    cfg_lo = l;
    send(15'h1, 1'b1, 8'h00);
    take();
    chk("frame_start", 16'h1, 16'(out_frame_start));
    step();
  endtask
  task automatic t_ho(input logic [1:0] r, h, input logic [15:0] col, d, c, b, x);
    frame(r, h, LO_NONE);
    send(col[COL_W-1:0], 1'b0, 8'h5a);
    take();
    chk("mid_frame", 16'h0, 16'(out_frame_start));
    chk("ho_d", d, 16'(out_ho_d));
    chk("ho_c", c, 16'(out_ho_c));
    chk("ho_b", b, 16'(out_ho_b));
    chk("ho_col", x, 16'(out_ho_col));
    step();
  endtask
  task automatic t_lo(input logic [1:0] lo, input logic [15:0] vc, k, l, m, x, ts);
    frame(RATE_STM1, HO_AU4, lo);
    send(vc[COL_W-1:0] + 15'h9, 1'b0, 8'h3c);
    take();
    chk("lo_valid", 16'h1, 16'(out_lo_valid));
    chk("vc4_col", vc, 16'(out_vc4_col));
    chk("lo_k", k, 16'(out_lo_k));
    chk("lo_l", l, 16'(out_lo_l));
    chk("lo_m", m, 16'(out_lo_m));
    chk("lo_col", x, 16'(out_lo_col));
    chk("lo_ts", ts, 16'(out_lo_ts));
    step();
  endtask
  task automatic t_edges();
    frame(RATE_STM1, HO_AU4, LO_TU12);
    send(15'h9, 1'b0, 8'h81);
    take();
    chk("data", 16'h81, 16'(out_data));
    chk("ovh9", 16'h1, 16'(out_overhead));
    step();
    send(15'hd, 1'b0, 8'h01);
    take();
    chk("ovh13", 16'h0, 16'(out_overhead));
    chk("stuff", 16'h0, 16'(out_lo_valid));
    step();
    send(15'h10f, 1'b0, 8'h02);
    take();
    chk("range", 16'h1, 16'(out_range_err));
    step();
  endtask
  task automatic t_cfg();
    frame(RATE_STM1, HO_AU4_16C, LO_NONE);
    chk("cfg_bad", 16'h1, 16'(cfg_err));
    frame(RATE_STM64, 2'h3, LO_NONE);
    chk("cfg_ho3", 16'h1, 16'(cfg_err));
    send(15'h14, 1'b0, 8'h00);
    take();
    chk("cfg_rng", 16'h1, 16'(out_range_err));
    step();
    frame(RATE_STM4, HO_AU4_4C, LO_NONE);
    chk("cfg_ok", 16'h0, 16'(cfg_err));
  endtask
  // sink stalls, fifo fills to refusal, then drains slowly in order
  task automatic t_fifo();
    frame(RATE_STM1, HO_AU4, LO_TU12);
    stall = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(15'h14 + 15'(i), 1'b0, 8'(i));
      step();
    end
    chk("full", 16'h0, 16'(in_ready));
    stall = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      take();
      chk("order", 16'h14 + 16'(i), 16'(out_col));
      step();
    end
    slow = 1'b0;
    chk("empty", 16'h0, 16'(out_valid));
    clk_en = 1'b0;
    step();
    chk("frozen", 16'h0, 16'(in_ready));
    clk_en = 1'b1;
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_edges();
    t_ho(RATE_STM1, HO_AU4, 16'h10e, 16'h0, 16'h0, 16'h0, 16'h10e);
    t_ho(RATE_STM4, HO_AU4, 16'h438, 16'h0, 16'h0, 16'h4, 16'h10e);
    t_ho(RATE_STM16, HO_AU4, 16'h10e0, 16'h0, 16'h4, 16'h4, 16'h10e);
    t_ho(RATE_STM16, HO_AU4_4C, 16'h11, 16'h0, 16'h1, 16'h0, 16'h5);
    t_ho(RATE_STM16, HO_AU4_16C, 16'h10e0, 16'h0, 16'h0, 16'h0, 16'h10e0);
    t_ho(RATE_STM64, HO_AU4, 16'h56, 16'h2, 16'h2, 16'h2, 16'h2);
    t_ho(RATE_STM64, HO_AU4, 16'h4380, 16'h4, 16'h4, 16'h4, 16'h10e);
    t_ho(RATE_STM64, HO_AU4_4C, 16'h4380, 16'h4, 16'h4, 16'h0, 16'h438);
    t_ho(RATE_STM64, HO_AU4_16C, 16'h4380, 16'h4, 16'h0, 16'h0, 16'h10e0);
    t_lo(LO_TU12, 16'ha, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1);
    t_lo(LO_TU12, 16'h105, 16'h3, 16'h7, 16'h3, 16'h4, 16'h3f);
    t_lo(LO_TU2, 16'h1e, 16'h3, 16'h7, 16'h0, 16'h1, 16'h15);
    t_lo(LO_TU2, 16'h105, 16'h3, 16'h7, 16'h0, 16'hc, 16'h15);
    t_lo(LO_TU3, 16'h4, 16'h1, 16'h0, 16'h0, 16'h1, 16'h1);
    t_lo(LO_TU3, 16'h105, 16'h3, 16'h0, 16'h0, 16'h56, 16'h3);
    t_cfg();
    t_fifo();
    wrap_up();
  end
endmodule
`default_nettype wire
